// [inc/asu_pkg.sv]
package asu_pkg;

	// Register offsets on the 3-bit register port
	localparam logic [2:0] ASU_OFS_CTRL_ONE = 3'h0;
	localparam logic [2:0] ASU_OFS_CTRL_TWO = 3'h1;
	localparam logic [2:0] ASU_OFS_CTRL_THREE = 3'h2;
	localparam logic [2:0] ASU_OFS_STATUS = 3'h3;
	localparam logic [2:0] ASU_OFS_DATA = 3'h4;
	localparam logic [2:0] ASU_OFS_EVT = 3'h5;
	localparam logic [2:0] ASU_OFS_MASK = 3'h6;

	// serial_control_two field positions
	localparam int ASU_C2_TX_EMPTY_IE = 7;
	localparam int ASU_C2_TX_DONE_IE = 6;
	localparam int ASU_C2_RX_FULL_IE = 5;
	localparam int ASU_C2_QUIET_IE = 4;
	localparam int ASU_C2_TX_ON = 3;
	localparam int ASU_C2_RX_ON = 2;
	localparam int ASU_C2_RX_STANDBY = 1;
	localparam int ASU_C2_BRK_SEND = 0;
	localparam logic [7:0] ASU_C2_RESET = 8'h00;

	// Control one / three field positions
	localparam int ASU_C1_LOOPBACK = 7;
	localparam int ASU_C1_RX_SOURCE = 5;
	localparam int ASU_C1_ROUSE = 3;
	localparam int ASU_C3_ONE_LINE_DIR = 0;
	localparam int ASU_C3_LONG_BRK = 1;

	// Status field positions (flag vector bits 3:0 map to 7:4)
	localparam int ASU_ST_TX_EMPTY = 3;
	localparam int ASU_ST_TX_DONE = 2;
	localparam int ASU_ST_RX_FULL = 1;
	localparam int ASU_ST_QUIET = 0;

	// Frame timing in oversample ticks and bit times
	localparam logic [3:0] ASU_TICK_LAST = 4'hf;
	localparam logic [3:0] ASU_TICK_MID = 4'h7;
	localparam logic [3:0] ASU_FRAME_BITS = 4'ha;
	localparam logic [3:0] ASU_BRK_BITS = 4'ha;
	localparam logic [3:0] ASU_LONG_BRK_BITS = 4'hd;
	localparam logic [3:0] ASU_QUIET_BITS = 4'ha;
	localparam logic [2:0] ASU_DATA_LAST = 3'h7;

	// Transmit sequencer states
	typedef enum logic [1:0] {
		ASU_TX_IDLE = 2'b01,
		ASU_TX_SEND = 2'b10
	} asu_tx_state_type;

	// Receive sequencer states
	typedef enum logic [3:0] {
		ASU_RX_IDLE = 4'b0001,
		ASU_RX_START = 4'b0010,
		ASU_RX_DATA = 4'b0100,
		ASU_RX_STOP = 4'b1000
	} asu_rx_state_type;

	// Register port request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [2:0] addr;
		logic [7:0] wdata;
	} asu_bus_req_type;

	// Whole state of the unit
	typedef struct packed {
		logic [7:0] ctrl2;
		logic [7:0] ctrl1;
		logic [7:0] ctrl3;
		asu_tx_state_type tx_st;
		logic [9:0] tx_sh;
		logic tx_fill;
		logic [3:0] tx_bits;
		logic [3:0] tx_sub;
		logic [7:0] tx_buf;
		logic tx_buf_empty;
		logic tx_done;
		logic idle_pend;
		logic brk_pend;
		asu_rx_state_type rx_st;
		logic [7:0] rx_sh;
		logic [2:0] rx_bits;
		logic [3:0] rx_sub;
		logic [7:0] rx_data;
		logic rx_buf_full;
		logic line_quiet;
		logic [3:0] quiet_cnt;
		logic quiet_armed;
		logic stat_seen;
		logic [2:0] rx_sync;
		logic rx_filt;
		logic [2:0] tp_sync;
		logic tp_filt;
		logic [3:0] flags_old;
		logic [3:0] evt;
		logic [3:0] mask;
		logic [7:0] rdata;
	} asu_state_type;

endpackage : asu_pkg

// [design/asu_ctrl_two.sv]
`timescale 1ns/100ps

module asu_ctrl_two (
	input wire logic ref_clk_i, // Bus clock
	input wire logic rst_b_i, // Async reset, active low
	input wire asu_pkg::asu_bus_req_type bus_i, // Register request
	output logic [7:0] rdata_o, // Read data, cycle after read
	input wire logic samp_tick_i, // 16x bit-rate tick
	input wire logic rx_pin_i, // Receive pin level
	output logic rx_pin_own_o, // Receiver owns rx pin
	input wire logic tx_pin_i, // Tx pin level from pad
	output logic tx_pin_o, // Tx pin drive value
	output logic tx_pin_oe_o, // Tx pin output enable
	output logic tx_pin_own_o, // Transmitter owns tx pin
	output logic irq_o // Interrupt request, level
);
	import asu_pkg::*;

	// Layout of the unit:
	// - the three control registers sit in one state struct
	// - the transmitter is a two-state sequencer around a shifter
	// - the receiver is a four-state sequencer around a shifter
	// - status flags are live; events are sticky copies of them
	// - every output comes from the registered state, so an
	//   output never follows a bus strobe in the same cycle
	// All timing counts step on samp_tick_i, which runs on the
	// bus clock, so no crossing logic is needed for the tick.
	// Only the two pads are asynchronous and they are filtered.

	asu_state_type s_q; // Registered state
	asu_state_type s_d; // Next state

	logic loop_mode; // Internal or single-wire loop
	logic one_wire; // Single-wire use of tx pin
	logic tx_line; // Transmitter serial output
	logic rx_line; // Receiver input after selection
	logic [3:0] flags; // Live status flags
	logic [3:0] flags_new; // Flags after this cycle

	// Mode decode from the control registers
	always_comb begin
		loop_mode = s_q.ctrl1[ASU_C1_LOOPBACK];
		one_wire = loop_mode & s_q.ctrl1[ASU_C1_RX_SOURCE];
		tx_line = (s_q.tx_st == ASU_TX_SEND) ? s_q.tx_sh[0] : 1'b1;
		// Receiver takes the transmitter or the tx pad in loop modes
		if (one_wire) begin
			rx_line = s_q.ctrl3[ASU_C3_ONE_LINE_DIR] ? tx_line
				: s_q.tp_filt;
		end else if (loop_mode) begin
			rx_line = tx_line;
		end else begin
			rx_line = s_q.rx_filt;
		end
		flags = {s_q.tx_buf_empty, s_q.tx_done, s_q.rx_buf_full,
			s_q.line_quiet};
	end

	// Pin ownership and drive
	always_comb begin
		// Owned while enabled or while anything is still queued
		tx_pin_own_o = s_q.ctrl2[ASU_C2_TX_ON] | (s_q.tx_st == ASU_TX_SEND)
			| s_q.idle_pend | s_q.brk_pend | ~s_q.tx_buf_empty;
		// Single-wire receive direction turns the pad around
		tx_pin_oe_o = tx_pin_own_o & ~(one_wire
			& ~s_q.ctrl3[ASU_C3_ONE_LINE_DIR]);
		tx_pin_o = tx_line;
		// Loopback never uses the rx pad
		rx_pin_own_o = s_q.ctrl2[ASU_C2_RX_ON]
			& ~loop_mode;
		rdata_o = s_q.rdata;
	end

	logic [3:0] irq_src; // Enabled live flags, status order

	// Each enable gates only its own flag; the request is a level,
	// so it stays up as long as software leaves a flag set.
	// Polling software leaves all four enables and the event mask clear.
	always_comb begin
		irq_src[3] = s_q.tx_buf_empty
			& s_q.ctrl2[ASU_C2_TX_EMPTY_IE];
		irq_src[2] = s_q.tx_done
			& s_q.ctrl2[ASU_C2_TX_DONE_IE];
		irq_src[1] = s_q.rx_buf_full
			& s_q.ctrl2[ASU_C2_RX_FULL_IE];
		irq_src[0] = s_q.line_quiet
			& s_q.ctrl2[ASU_C2_QUIET_IE];
		// Sticky events add a second, edge-style path
		irq_o = |irq_src
			| |(s_q.evt & s_q.mask);
	end

	// Next-state logic for the whole unit
	always_comb begin
		logic brk_now; // Break to start next
		s_d = s_q;
		brk_now = 1'b0;

		// Pad synchronisers: stages two and three are compared
		// Stage two and three must agree before the filtered level
		// moves, which rejects a single-cycle glitch on the pad.
		// The cost is two extra cycles of latency, which is small
		// against a bit time of sixteen ticks.
		s_d.rx_sync = {s_q.rx_sync[1:0], rx_pin_i};
		s_d.tp_sync = {s_q.tp_sync[1:0], tx_pin_i};
		if (s_q.rx_sync[1] == s_q.rx_sync[2]) begin
			s_d.rx_filt = s_q.rx_sync[2];
		end
		if (s_q.tp_sync[1] == s_q.tp_sync[2]) begin
			s_d.tp_filt = s_q.tp_sync[2];
		end

		// Transmit sequencer
		// The shifter is loaded with a whole frame and shifted
		// right once per bit time; tx_fill is what enters at the
		// top, one for frames and idle, zero for breaks.
		// tx_bits counts the bit times left in the frame.
		// A held break bit starts a new break every time the
		// sequencer falls idle, so breaks can run back to back.
		// Breaks only repeat while the transmitter is on; a
		// queued one still drains after it is turned off.
		case (s_q.tx_st)
			ASU_TX_IDLE: begin
				// Break first, then queued idle, then data
				brk_now = s_q.brk_pend
					| (s_q.ctrl2[ASU_C2_BRK_SEND]
					& s_q.ctrl2[ASU_C2_TX_ON]);
				s_d.tx_sub = 4'h0;
				if (brk_now) begin
					s_d.tx_st = ASU_TX_SEND;
					s_d.tx_sh = 10'h000;
					s_d.tx_fill = 1'b0;
					s_d.tx_bits = s_q.ctrl3[ASU_C3_LONG_BRK]
						? ASU_LONG_BRK_BITS : ASU_BRK_BITS;
					s_d.brk_pend = 1'b0;
				end else if (s_q.idle_pend) begin
					s_d.tx_st = ASU_TX_SEND;
					s_d.tx_sh = 10'h3ff;
					s_d.tx_fill = 1'b1;
					s_d.tx_bits = ASU_FRAME_BITS;
					s_d.idle_pend = 1'b0;
				end else if (~s_q.tx_buf_empty) begin
					// Buffer moves to the shifter, buffer frees up
					s_d.tx_st = ASU_TX_SEND;
					s_d.tx_sh = {1'b1, s_q.tx_buf, 1'b0};
					s_d.tx_fill = 1'b1;
					s_d.tx_bits = ASU_FRAME_BITS;
					s_d.tx_buf_empty = 1'b1;
				end
			end
			ASU_TX_SEND: begin
				if (samp_tick_i) begin
					s_d.tx_sub = s_q.tx_sub + 4'h1;
					if (s_q.tx_sub == ASU_TICK_LAST) begin
						s_d.tx_sh = {s_q.tx_fill, s_q.tx_sh[9:1]};
						s_d.tx_bits = s_q.tx_bits - 4'h1;
						if (s_q.tx_bits == 4'h1) begin
							s_d.tx_st = ASU_TX_IDLE;
						end
					end
				end
			end
			default: begin
				s_d.tx_st = ASU_TX_IDLE;
			end
		endcase

		// Receive sequencer; held idle while the receiver is off
		// A start is taken on any low sample and confirmed half a
		// bit later; data bits are then sampled at mid-bit.
		// The quiet counter only runs while the line is high in
		// idle, and quiet_armed makes the quiet event fire once
		// after each received frame or run of frames, however long the line stays high.
		// Turning the receiver off mid-frame drops that frame.
		if (~s_q.ctrl2[ASU_C2_RX_ON]) begin
			s_d.rx_st = ASU_RX_IDLE;
			s_d.rx_sub = 4'h0;
			s_d.quiet_cnt = 4'h0;
		end else if (samp_tick_i) begin
			s_d.rx_sub = s_q.rx_sub + 4'h1;
			case (s_q.rx_st)
				ASU_RX_IDLE: begin
					if (~rx_line) begin
						s_d.rx_st = ASU_RX_START;
						s_d.rx_sub = 4'h0;
						s_d.quiet_cnt = 4'h0;
					end else if (s_q.rx_sub == ASU_TICK_LAST
						&& s_q.quiet_cnt != ASU_QUIET_BITS) begin
						s_d.quiet_cnt = s_q.quiet_cnt + 4'h1;
					end
				end
				ASU_RX_START: begin
					// Mid-bit check rejects glitches
					if (s_q.rx_sub == ASU_TICK_MID) begin
						s_d.rx_sub = 4'h0;
						s_d.rx_bits = 3'h0;
						s_d.rx_st = rx_line ? ASU_RX_IDLE : ASU_RX_DATA;
					end
				end
				ASU_RX_DATA: begin
					if (s_q.rx_sub == ASU_TICK_LAST) begin
						s_d.rx_sh = {rx_line, s_q.rx_sh[7:1]};
						s_d.rx_bits = s_q.rx_bits + 3'h1;
						if (s_q.rx_bits == ASU_DATA_LAST) begin
							s_d.rx_st = ASU_RX_STOP;
						end
					end
				end
				ASU_RX_STOP: begin
					if (s_q.rx_sub == ASU_TICK_LAST) begin
						s_d.rx_st = ASU_RX_IDLE;
						s_d.rx_sub = 4'h0;
						s_d.quiet_armed = 1'b1;
					end
				end
				default: begin
					s_d.rx_st = ASU_RX_IDLE;
				end
			endcase
		end

		// Flag clearing: status read, then data read
		// The status read arms the clear; a data read without it
		// leaves both receive flags alone, so a stray data read
		// cannot lose a pending receive or quiet indication.
		if (bus_i.rd && bus_i.addr == ASU_OFS_STATUS) begin
			s_d.stat_seen = 1'b1;
		end
		if (bus_i.rd && bus_i.addr == ASU_OFS_DATA && s_q.stat_seen) begin
			s_d.rx_buf_full = 1'b0;
			s_d.line_quiet = 1'b0;
			s_d.stat_seen = 1'b0;
		end

		// Register writes; all writes accepted at any time
		// No write is refused or delayed by transfer activity:
		// a change of tx_on or brk_send is picked up by the
		// sequencer at its next idle point, not mid-frame.
		// Offsets that are not decoded are ignored silently.
		if (bus_i.wr) begin
			if (bus_i.addr == ASU_OFS_CTRL_ONE) begin
				s_d.ctrl1 = bus_i.wdata;
			end else if (bus_i.addr == ASU_OFS_CTRL_TWO) begin
				s_d.ctrl2 = bus_i.wdata;
				// Enable edge queues one idle character
				if (bus_i.wdata[ASU_C2_TX_ON]
					&& ~s_q.ctrl2[ASU_C2_TX_ON]) begin
					s_d.idle_pend = 1'b1;
				end
				// A set of the break bit guarantees one break
				if (bus_i.wdata[ASU_C2_BRK_SEND]
					&& ~s_q.ctrl2[ASU_C2_BRK_SEND]) begin
					s_d.brk_pend = 1'b1;
				end
			end else if (bus_i.addr == ASU_OFS_CTRL_THREE) begin
				s_d.ctrl3 = bus_i.wdata;
			end else if (bus_i.addr == ASU_OFS_DATA) begin
				// New data in the buffer; overwrites if still full
				s_d.tx_buf = bus_i.wdata;
				s_d.tx_buf_empty = 1'b0;
				s_d.stat_seen = 1'b0;
			end else if (bus_i.addr == ASU_OFS_EVT) begin
				s_d.evt = s_q.evt & ~bus_i.wdata[3:0];
			end else if (bus_i.addr == ASU_OFS_MASK) begin
				s_d.mask = bus_i.wdata[3:0];
			end
		end

		// Hardware events come last so a set beats a clear
		// A receive flag set in the same cycle as a software
		// clear stays set, so no received frame goes unseen.
		// In standby a frame is only delivered when it wakes
		// the receiver through the address mark.
		if (s_q.ctrl2[ASU_C2_RX_ON] && samp_tick_i) begin
			if (s_q.rx_st == ASU_RX_STOP && s_q.rx_sub == ASU_TICK_LAST) begin
				// Address mark ends standby and is delivered
				if (s_q.ctrl2[ASU_C2_RX_STANDBY]
					&& s_q.ctrl1[ASU_C1_ROUSE] && s_q.rx_sh[7]) begin
					s_d.ctrl2[ASU_C2_RX_STANDBY] = 1'b0;
				end
				if (~s_q.ctrl2[ASU_C2_RX_STANDBY]
					|| (s_q.ctrl1[ASU_C1_ROUSE] && s_q.rx_sh[7])) begin
					s_d.rx_data = s_q.rx_sh;
					s_d.rx_buf_full = 1'b1;
				end
			end
			// A full quiet character after activity
			if (s_q.rx_st == ASU_RX_IDLE && rx_line
				&& s_q.rx_sub == ASU_TICK_LAST
				&& s_q.quiet_cnt == ASU_QUIET_BITS - 4'h1
				&& s_q.quiet_armed) begin
				s_d.quiet_armed = 1'b0;
				if (s_q.ctrl2[ASU_C2_RX_STANDBY]) begin
					if (~s_q.ctrl1[ASU_C1_ROUSE]) begin
						s_d.ctrl2[ASU_C2_RX_STANDBY] = 1'b0;
					end
				end else begin
					s_d.line_quiet = 1'b1;
				end
			end
		end

		// Done while nothing is buffered, queued or shifting
		s_d.tx_done = s_d.tx_buf_empty && s_d.tx_st == ASU_TX_IDLE
			&& ~s_d.idle_pend && ~s_d.brk_pend;

		// Sticky events on each rising flag
		flags_new = {s_d.tx_buf_empty, s_d.tx_done, s_d.rx_buf_full,
			s_d.line_quiet};
		s_d.flags_old = flags_new;
		s_d.evt = s_d.evt | (flags_new & ~s_q.flags_old);

		// Read data for the following cycle
		// Read data is registered and zero outside a read slot;
		// reads never change control state, only the status
		// read arms the receive flag clear above.
		s_d.rdata = 8'h00;
		if (bus_i.rd) begin
			if (bus_i.addr == ASU_OFS_CTRL_ONE) begin
				s_d.rdata = s_q.ctrl1;
			end else if (bus_i.addr == ASU_OFS_CTRL_TWO) begin
				s_d.rdata = s_q.ctrl2;
			end else if (bus_i.addr == ASU_OFS_CTRL_THREE) begin
				s_d.rdata = s_q.ctrl3;
			end else if (bus_i.addr == ASU_OFS_STATUS) begin
				s_d.rdata = {flags, 4'h0};
			end else if (bus_i.addr == ASU_OFS_DATA) begin
				s_d.rdata = s_q.rx_data;
			end else if (bus_i.addr == ASU_OFS_EVT) begin
				s_d.rdata = {4'h0, s_q.evt};
			end else if (bus_i.addr == ASU_OFS_MASK) begin
				s_d.rdata = {4'h0, s_q.mask};
			end
		end
	end

	// State register; buffer empty and done start set
	// The old-flag copy starts equal to the reset flags so that
	// no sticky event appears just after reset. Synchronisers
	// start at the idle level of the pads, so no false start
	// bit is seen while they fill.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q <= '0;
			s_q.ctrl2 <= ASU_C2_RESET;
			s_q.tx_st <= ASU_TX_IDLE;
			s_q.rx_st <= ASU_RX_IDLE;
			s_q.tx_buf_empty <= 1'b1;
			s_q.tx_done <= 1'b1;
			s_q.flags_old <= 4'hc;
			s_q.rx_sync <= 3'h7;
			s_q.rx_filt <= 1'b1;
			s_q.tp_sync <= 3'h7;
			s_q.tp_filt <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : asu_ctrl_two

// [sim/asu_ctrl_two_checker.sv]
`timescale 1ns/100ps
// Port-level watch on the control-two register and the pad controls
module asu_ctrl_two_checker (
	input wire logic ref_clk_i, // Bus clock
	input wire logic rst_b_i, // Reset, active low
	input wire asu_pkg::asu_bus_req_type bus_i, // Register request
	input wire logic [7:0] rdata_o, // Read data
	input wire logic samp_tick_i, // Bit tick
	input wire logic rx_pin_i, // Rx pad
	input wire logic rx_pin_own_o, // Rx owned
	input wire logic tx_pin_i, // Tx pad
	input wire logic tx_pin_o, // Tx drive
	input wire logic tx_pin_oe_o, // Tx enable
	input wire logic tx_pin_own_o, // Tx owned
	input wire logic irq_o // Interrupt
);
	import asu_pkg::*;
	logic [7:0] c1_q, c2_q, c3_q, mk_q; // Shadows of software writes
	// Standby bit is cleared by hardware, so it is masked below
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			{c1_q, c2_q, c3_q, mk_q} <= '0;
		end else if (bus_i.wr) begin
			if (bus_i.addr == ASU_OFS_CTRL_ONE) c1_q <= bus_i.wdata;
			if (bus_i.addr == ASU_OFS_CTRL_TWO) c2_q <= bus_i.wdata;
			if (bus_i.addr == ASU_OFS_CTRL_THREE) c3_q <= bus_i.wdata;
			if (bus_i.addr == ASU_OFS_MASK) mk_q <= bus_i.wdata;
		end
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	AST_RD_QUIET: assert property (
		!$past(bus_i.rd) |-> rdata_o == 8'h00)
		else $error("read data outside read slot");
	AST_RD_C2: assert property (
		$past(bus_i.rd && bus_i.addr == ASU_OFS_CTRL_TWO)
		|-> (rdata_o & 8'hfd) == ($past(c2_q) & 8'hfd))
		else $error("ctrl2 readback");
	AST_RX_OWN: assert property (
		rx_pin_own_o == (c2_q[2] && !c1_q[7]))
		else $error("rx pin ownership");
	AST_TX_OWN: assert property (c2_q[3] |-> tx_pin_own_o)
		else $error("tx pin not owned");
	AST_ONE_WIRE: assert property (c1_q[7] && c1_q[5] && c2_q[3]
		|-> tx_pin_oe_o == c3_q[0]) else $error("single-wire direction");
	AST_LOW_OWNED: assert property (!tx_pin_o |-> tx_pin_own_o)
		else $error("traffic on released pin");
	AST_IRQ_OFF: assert property (
		c2_q[7:4] == 4'h0 && mk_q[3:0] == 4'h0 |-> !irq_o)
		else $error("irq with all sources off");
	AST_IRQ_ON: assert property (
		$past(bus_i.rd && bus_i.addr == ASU_OFS_STATUS)
		&& (rdata_o[7:4] & c2_q[7:4]) != 4'h0 |-> irq_o)
		else $error("irq missing");
	AST_BRK_START: assert property ($rose(c2_q[0]) && c2_q[3]
		|-> ##[1:800] !tx_pin_o) else $error("break never sent");
endmodule : asu_ctrl_two_checker

bind asu_ctrl_two asu_ctrl_two_checker u_asu_ctrl_two_checker (
	.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .bus_i(bus_i),
	.rdata_o(rdata_o), .samp_tick_i(samp_tick_i), .rx_pin_i(rx_pin_i),
	.rx_pin_own_o(rx_pin_own_o), .tx_pin_i(tx_pin_i), .tx_pin_o(tx_pin_o),
	.tx_pin_oe_o(tx_pin_oe_o), .tx_pin_own_o(tx_pin_own_o), .irq_o(irq_o));

// [sim/asu_serial_node.sv]
`timescale 1ns/100ps
// Remote node: start, 8 data LSB first, stop; line idles high
module asu_serial_node #(
	parameter int BIT_CYC = 32 // Clock cycles per bit
) (
	input wire logic clk_i, // Bus clock
	input wire logic line_i, // Line from the device
	output logic line_o, // Line to the device
	output logic [7:0] last_o, // Last byte heard
	output int brk_o // Breaks heard
);
	logic [9:0] fr; // Frame being heard
	initial begin
		line_o = 1'b1;
		last_o = 8'h00;
		brk_o = 0;
	end
	// Send one frame
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_o <= f[i];
			repeat (BIT_CYC) @(posedge clk_i);
		end
	endtask : send
	// Level start detect, so back-to-back breaks are each counted
	always begin
		do @(posedge clk_i); while (line_i !== 1'b0);
		repeat (BIT_CYC / 2) @(posedge clk_i);
		for (int i = 0; i < 10; i++) begin
			if (i > 0) repeat (BIT_CYC) @(posedge clk_i);
			fr[i] = line_i;
		end
		// All-zero frame is a break, else a byte
		if (fr == 10'h000) brk_o++;
		else last_o = fr[8:1];
		repeat (BIT_CYC / 2 - 2) @(posedge clk_i);
	end
endmodule : asu_serial_node

// [sim/asu_ctrl_two_bench.sv]
`timescale 1ns/100ps
// Register-level tests of the second control register
module asu_ctrl_two_bench;
	import asu_pkg::*;
	logic ref_clk = 1'b0; // Bus clock
	logic rst_b = 1'b0; // Reset, active low
	logic tick = 1'b0; // Bit tick every other cycle: 32 cycles a bit
	asu_bus_req_type bus = '0; // Register request
	logic [7:0] rdata, last, v; // Read data, node byte, scratch
	logic rx_line, rx_own, tx_pad, tx_o, tx_oe, tx_own, irq; // Pads
	int nbrk, base, miscompares = 0, checked = 0; // Counters
	// Pull-up holds the tx pad high when undriven
	assign tx_pad = tx_oe ? tx_o : 1'b1;
	always #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk) tick <= ~tick;
	asu_ctrl_two u_asu_ctrl_two (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
		.bus_i(bus), .rdata_o(rdata), .samp_tick_i(tick), .rx_pin_i(rx_line),
		.rx_pin_own_o(rx_own), .tx_pin_i(tx_pad), .tx_pin_o(tx_o),
		.tx_pin_oe_o(tx_oe), .tx_pin_own_o(tx_own), .irq_o(irq));
	asu_serial_node u_asu_serial_node (.clk_i(ref_clk), .line_i(tx_pad),
		.line_o(rx_line), .last_o(last), .brk_o(nbrk));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// One-cycle strobes; sampled just after the edge that takes them
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge ref_clk);
		bus.wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rchk(input string n, input logic [2:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge ref_clk);
		bus.rd <= 1'b0;
		#1 v = rdata;
		chk(n, e, v);
	endtask : rchk
	task automatic bits(input int n);
		repeat (n * 32) @(posedge ref_clk);
		#1;
	endtask : bits
	task automatic print_verdict;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		rchk("ctrl2", ASU_OFS_CTRL_TWO, ASU_C2_RESET);
		rchk("status", ASU_OFS_STATUS, 8'hc0);
		rchk("unmapped", 3'h7, 8'h00);
		// Only the two tx flags are set out of reset
		for (int i = 0; i < 4; i++) begin
			wr(ASU_OFS_CTRL_TWO, 8'h80 >> i);
			chk("irq_en", {7'h0, i < 2}, {7'h0, irq});
		end
		// Receive a byte, then walk rx enables and the event mask
		wr(ASU_OFS_CTRL_TWO, 8'h24);
		chk("rx_own", 8'h01, {7'h0, rx_own});
		u_asu_serial_node.send(8'h5a);
		bits(12);
		chk("irq_full", 8'h01, {7'h0, irq});
		wr(ASU_OFS_CTRL_TWO, 8'h14);
		chk("irq_quiet", 8'h01, {7'h0, irq});
		wr(ASU_OFS_CTRL_TWO, 8'h04);
		chk("irq_off", 8'h00, {7'h0, irq});
		wr(ASU_OFS_MASK, 8'h02);
		chk("irq_evt", 8'h01, {7'h0, irq});
		rchk("st_rx", ASU_OFS_STATUS, 8'hf0);
		rchk("data", ASU_OFS_DATA, 8'h5a);
		rchk("st_clr", ASU_OFS_STATUS, 8'hc0);
		wr(ASU_OFS_EVT, 8'h0f);
		chk("irq_w1c", 8'h00, {7'h0, irq});
		wr(ASU_OFS_MASK, 8'h00);
		// Internal loop: preamble, frame, then quiet time
		wr(ASU_OFS_CTRL_ONE, 8'h80);
		chk("rx_loop", 8'h00, {7'h0, rx_own});
		wr(ASU_OFS_CTRL_TWO, 8'h0c);
		wr(ASU_OFS_DATA, 8'h3c);
		bits(34);
		rchk("st_loop", ASU_OFS_STATUS, 8'hf0);
		rchk("loop", ASU_OFS_DATA, 8'h3c);
		wr(ASU_OFS_CTRL_ONE, 8'ha0);
		wr(ASU_OFS_CTRL_THREE, 8'h00);
		chk("oe_in", 8'h00, {7'h0, tx_oe});
		wr(ASU_OFS_CTRL_THREE, 8'h01);
		chk("oe_out", 8'h01, {7'h0, tx_oe});
		wr(ASU_OFS_CTRL_ONE, 8'h00);
		// Turning tx off mid-frame must not cut the frame short
		wr(ASU_OFS_DATA, 8'ha3);
		wr(ASU_OFS_CTRL_TWO, 8'h00);
		chk("own_drain", 8'h01, {7'h0, tx_own});
		for (int i = 0; i < 2000 && tx_own; i++) @(posedge ref_clk);
		#1 chk("node_byte", 8'ha3, last);
		chk("own_free", 8'h00, {7'h0, tx_own});
		rchk("st_tx", ASU_OFS_STATUS, 8'hc0);
		// Break: one from a quick 1-then-0, several while held
		wr(ASU_OFS_CTRL_TWO, 8'h08);
		bits(12);
		base = nbrk;
		wr(ASU_OFS_CTRL_TWO, 8'h09);
		wr(ASU_OFS_CTRL_TWO, 8'h08);
		bits(14);
		chk("brk_one", 8'h01, 8'(nbrk - base));
		wr(ASU_OFS_CTRL_TWO, 8'h09);
		bits(35);
		wr(ASU_OFS_CTRL_TWO, 8'h08);
		bits(14);
		chk("brk_held", 8'h01, {7'h0, nbrk - base >= 4});
		// Standby: quiet-line wakeup, then address mark wakeup
		for (int r = 0; r < 2; r++) begin
			wr(ASU_OFS_CTRL_ONE, r ? 8'h08 : 8'h00);
			wr(ASU_OFS_CTRL_TWO, 8'h06);
			u_asu_serial_node.send(8'h12);
			bits(12);
			rchk("standby", ASU_OFS_CTRL_TWO, r ? 8'h06 : 8'h04);
		end
		u_asu_serial_node.send(8'h81);
		bits(2);
		rchk("mark_wake", ASU_OFS_CTRL_TWO, 8'h04);
		print_verdict;
	end
	// Whole run is near 6400 cycles; this allows nearly eight times that
	initial begin
		#400000;
		miscompares++;
		print_verdict;
	end
endmodule : asu_ctrl_two_bench
